// [rtl/scsi_target_phase_sequencer.v]
// Target-side information transfer phase sequencer for a parallel SCSI disk.
`include "scsi_seq_consts.vh"
module scsi_target_phase_sequencer #(
   parameter BLOCK_BYTES = 512,
   parameter FIFO_DEPTH = 16,
   parameter FIFO_AW = 4,
   parameter [7:0] PARITY_ASC = 8'h00,
   parameter [7:0] REQ_SENSE_OP = 8'h03,
   parameter [7:0] INQUIRY_OP = 8'h12
) (
   input wire clk_in,
   input wire rst_n_in,
   input wire ack_in,
   input wire atn_in,
   input wire [7:0] db_in,
   input wire dbp_in,
   output reg req_out,
   output reg cd_out,
   output reg io_out,
   output reg msg_out,
   output reg bsy_out,
   output reg [7:0] db_out,
   output reg dbp_out,
   output reg db_oe_out,
   input wire sel_start_in,
   input wire sel_atn_in,
   input wire sel_id_ok_in,
   input wire [2:0] sel_init_in,
   input wire parity_en_in,
   input wire busy_in,
   input wire reserved_in,
   input wire [2:0] reserve_owner_in,
   input wire queue_full_in,
   output reg [7:0] cdb_byte_out,
   output reg cdb_valid_out,
   output reg cdb_last_out,
   input wire plan_valid_in,
   input wire [1:0] plan_dir_in,
   input wire [15:0] plan_len_in,
   input wire end_valid_in,
   input wire end_check_in,
   input wire [3:0] end_key_in,
   input wire [7:0] end_asc_in,
   input wire din_valid_in,
   input wire [7:0] din_byte_in,
   output wire din_ready_out,
   output reg [7:0] dout_byte_out,
   output reg dout_valid_out,
   input wire dout_ready_in,
   output reg disc_ok_out,
   output reg cleared_out,
   input wire [2:0] sense_sel_in,
   output reg sense_valid_out,
   output reg [11:0] sense_out
);
   localparam [7:0] S_FREE = 8'h01;
   localparam [7:0] S_MSGO = 8'h02;
   localparam [7:0] S_CMD = 8'h04;
   localparam [7:0] S_EXEC = 8'h08;
   localparam [7:0] S_DIN = 8'h10;
   localparam [7:0] S_DOUT = 8'h20;
   localparam [7:0] S_STAT = 8'h40;
   localparam [7:0] S_MSGI = 8'h80;
   localparam [3:0] H_IDLE = 4'h1;
   localparam [3:0] H_WAIT = 4'h2;
   localparam [3:0] H_REQ = 4'h4;
   localparam [3:0] H_REL = 4'h8;
   localparam integer SETTLE_I = `SETTLE_CYC;
   localparam integer SKEW_I = `SKEW_CYC;
   localparam integer BLK_I = BLOCK_BYTES - 1;
   localparam [7:0] SETTLE_C = SETTLE_I[7:0];
   localparam [7:0] SKEW_C = SKEW_I[7:0];
   localparam [15:0] BLK_LAST = BLK_I[15:0];

   // Pin inputs: three stages, a change counts once stages two and three agree.
   reg [10:0] s1_q;
   reg [10:0] s2_q;
   reg [10:0] s3_q;
   reg [10:0] f_q;
   wire ack_f = f_q[10];
   wire atn_f = f_q[9];
   wire [8:0] dbf = f_q[8:0];

   reg [7:0] st_q;
   reg [3:0] hs_q;
   reg [7:0] tmr_q;
   reg chg_q;
   reg [7:0] rx_q;
   reg bad_q;
   reg [2:0] init_q;
   reg idok_q;
   reg first_q;
   reg cc_q;
   reg qfull_q;
   reg link_q;
   reg ext_q;
   reg planned_q;
   reg [7:0] mcnt_q;
   reg [7:0] ret_q;
   reg [3:0] idx_q;
   reg [3:0] len_q;
   reg [7:0] op_q;
   reg [15:0] cnt_q;
   reg [15:0] blk_q;
   reg [7:0] stat_q;
   reg [7:0] mi_q;
   reg flush_q;
   reg [7:0] sval_q;
   reg sense_we_q;
   reg [2:0] sense_wa_q;
   reg [11:0] sense_wd_q;
   reg [11:0] sense_mem [0:7];
   reg need_w;
   reg [7:0] tx_w;
   reg [7:0] cmd_nxt_w;
   reg [7:0] cmd_stat_w;
   wire fifo_v;
   wire [7:0] fifo_d;
   wire start_w = (hs_q == H_IDLE) & need_w;
   wire done_w = (hs_q == H_REL) & ~ack_f;
   wire blk_end_w = (blk_q == BLK_LAST);

   function [2:0] phase_of;
      input [7:0] s;
      begin
         case (s)
            S_CMD: phase_of = `PH_CMD;
            S_MSGO: phase_of = `PH_MSGO;
            S_DIN: phase_of = `PH_DIN;
            S_STAT: phase_of = `PH_STAT;
            S_MSGI: phase_of = `PH_MSGI;
            default: phase_of = `PH_DOUT;
         endcase
      end
   endfunction

   function [3:0] cdb_len;
      input [7:0] op;
      begin
         case (op[7:5])
            3'h0: cdb_len = 4'h6;
            3'h1: cdb_len = 4'hA;
            3'h2: cdb_len = 4'hA;
            3'h5: cdb_len = 4'hC;
            default: cdb_len = 4'h6;
         endcase
      end
   endfunction

   // The data-in buffer lets the media side run ahead of a slow initiator.
   seq_fifo #(.W(8), .D(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .flush_in(flush_q),
      .in_valid_in(din_valid_in),
      .in_data_in(din_byte_in),
      .in_ready_out(din_ready_out),
      .out_valid_out(fifo_v),
      .out_data_out(fifo_d),
      .out_ready_in(start_w & (st_q == S_DIN))
   );

   always @* begin
      need_w = (st_q == S_CMD) | (st_q == S_MSGO) | (st_q == S_STAT) | (st_q == S_MSGI);
      need_w = need_w | ((st_q == S_DIN) & fifo_v) | ((st_q == S_DOUT) & dout_ready_in);
      case (st_q)
         S_STAT: tx_w = stat_q & `ST_CODE_MASK;
         S_MSGI: tx_w = mi_q;
         default: tx_w = fifo_d;
      endcase
      cmd_nxt_w = S_STAT;
      if (qfull_q) begin
         cmd_stat_w = `ST_QFULL;
      end else if (busy_in) begin
         cmd_stat_w = `ST_BUSY;
      end else if (reserved_in && (reserve_owner_in != init_q)) begin
         cmd_stat_w = `ST_CONFLICT;
      end else begin
         cmd_stat_w = `ST_GOOD;
         cmd_nxt_w = S_EXEC;
      end
   end

   task go;
      input [7:0] s;
      begin
         st_q <= s;
         chg_q <= 1'b1;
         if (s != S_EXEC) begin
            {msg_out, cd_out, io_out} <= phase_of(s);
         end
         if (s == S_FREE) begin
            bsy_out <= 1'b0;
            flush_q <= 1'b1;
         end
      end
   endtask

   task set_sense;
      input [3:0] key;
      input [7:0] asc;
      begin
         sense_we_q <= 1'b1;
         sense_wa_q <= init_q;
         sense_wd_q <= {key, asc};
         sval_q[init_q] <= 1'b1;
      end
   endtask

   task msg_leave;
      begin
         if (!atn_f) begin
            if (cc_q) begin
               go(S_FREE);
            end else begin
               go(ret_q);
            end
         end
      end
   endtask

   task data_step;
      input [7:0] s;
      begin
         cnt_q <= cnt_q - 16'h0001;
         blk_q <= blk_end_w ? 16'h0000 : blk_q + 16'h0001;
         if (cnt_q == 16'h0001) begin
            go(S_EXEC);
         end else if (blk_end_w && atn_f) begin
            ret_q <= s;
            go(S_MSGO);
         end
      end
   endtask

   always @(posedge clk_in) begin
      if (sense_we_q) begin
         sense_mem[sense_wa_q] <= sense_wd_q;
      end
   end

   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1_q <= 11'h000;
         s2_q <= 11'h000;
         s3_q <= 11'h000;
         f_q <= 11'h000;
         sense_valid_out <= 1'b0;
         sense_out <= 12'h000;
      end else begin
         s1_q <= {ack_in, atn_in, dbp_in, db_in};
         s2_q <= s1_q;
         s3_q <= s2_q;
         f_q <= (~(s2_q ^ s3_q) & s2_q) | ((s2_q ^ s3_q) & f_q);
         sense_valid_out <= sval_q[sense_sel_in];
         sense_out <= sense_mem[sense_sel_in];
      end
   end

   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         req_out <= 1'b0;
         {msg_out, cd_out, io_out} <= 3'h0;
         bsy_out <= 1'b0;
         db_out <= 8'h00;
         dbp_out <= 1'b0;
         db_oe_out <= 1'b0;
         cdb_byte_out <= 8'h00;
         cdb_valid_out <= 1'b0;
         cdb_last_out <= 1'b0;
         dout_byte_out <= 8'h00;
         dout_valid_out <= 1'b0;
         disc_ok_out <= 1'b0;
         cleared_out <= 1'b0;
         st_q <= S_FREE;
         hs_q <= H_IDLE;
         tmr_q <= 8'h00;
         chg_q <= 1'b1;
         rx_q <= 8'h00;
         bad_q <= 1'b0;
         init_q <= 3'h0;
         idok_q <= 1'b0;
         first_q <= 1'b0;
         cc_q <= 1'b0;
         qfull_q <= 1'b0;
         link_q <= 1'b0;
         ext_q <= 1'b0;
         planned_q <= 1'b0;
         mcnt_q <= 8'h00;
         ret_q <= S_CMD;
         idx_q <= 4'h0;
         len_q <= 4'h6;
         op_q <= 8'h00;
         cnt_q <= 16'h0000;
         blk_q <= 16'h0000;
         stat_q <= `ST_GOOD;
         mi_q <= `MSG_CC;
         flush_q <= 1'b0;
         sval_q <= 8'h00;
         sense_we_q <= 1'b0;
         sense_wa_q <= 3'h0;
         sense_wd_q <= 12'h000;
      end else begin
         cdb_valid_out <= 1'b0;
         cdb_last_out <= 1'b0;
         dout_valid_out <= 1'b0;
         cleared_out <= 1'b0;
         sense_we_q <= 1'b0;
         flush_q <= 1'b0;
         case (hs_q)
            H_IDLE: if (start_w) begin
               tmr_q <= chg_q ? SETTLE_C : SKEW_C;
               chg_q <= 1'b0;
               db_out <= tx_w;
               dbp_out <= ~(^tx_w);
               db_oe_out <= io_out;
               hs_q <= H_WAIT;
            end
            H_WAIT: if (tmr_q <= 8'h01) begin
               req_out <= 1'b1;
               hs_q <= H_REQ;
            end else begin
               tmr_q <= tmr_q - 8'h01;
            end
            H_REQ: if (ack_f) begin
               rx_q <= dbf[7:0];
               bad_q <= parity_en_in & ~(^dbf) & ~io_out;
               req_out <= 1'b0;
               hs_q <= H_REL;
            end
            H_REL: if (!ack_f) begin
               db_oe_out <= 1'b0;
               hs_q <= H_IDLE;
            end
            default: hs_q <= H_IDLE;
         endcase
         case (st_q)
            S_FREE: if (sel_start_in) begin
               bsy_out <= 1'b1;
               init_q <= sel_init_in;
               idok_q <= sel_id_ok_in;
               first_q <= sel_atn_in;
               disc_ok_out <= 1'b0;
               cc_q <= 1'b0;
               qfull_q <= 1'b0;
               link_q <= 1'b0;
               ext_q <= 1'b0;
               mcnt_q <= 8'h00;
               idx_q <= 4'h0;
               ret_q <= S_CMD;
               if (sel_atn_in) begin
                  go(S_MSGO);
               end else begin
                  go(S_CMD);
               end
            end
            S_MSGO: if (done_w) begin
               first_q <= 1'b0;
               if (mcnt_q != 8'h00) begin
                  ext_q <= 1'b0;
                  mcnt_q <= ext_q ? rx_q : mcnt_q - 8'h01;
                  if ((ext_q ? rx_q : mcnt_q - 8'h01) == 8'h00) begin
                     msg_leave;
                  end
               end else if (first_q && !rx_q[7]) begin
                  set_sense(`KEY_ABORTED, `ASC_ILLMSG);
                  go(S_FREE);
               end else if (rx_q[7]) begin
                  disc_ok_out <= idok_q & first_q & rx_q[6];
                  msg_leave;
               end else begin
                  case (rx_q)
                     `MSG_ABORT, `MSG_BDR: begin
                        cleared_out <= 1'b1;
                        go(S_FREE);
                     end
                     `MSG_REJECT: msg_leave;
                     `MSG_TERM: begin
                        stat_q <= `ST_TERM;
                        go(S_STAT);
                     end
                     `MSG_SQT, `MSG_HQT, `MSG_OQT: begin
                        mcnt_q <= 8'h01;
                        qfull_q <= queue_full_in;
                     end
                     `MSG_EXT: begin
                        mcnt_q <= 8'h01;
                        ext_q <= 1'b1;
                     end
                     default: msg_leave;
                  endcase
               end
            end
            S_CMD: if (done_w) begin
               if (bad_q) begin
                  set_sense(`KEY_ABORTED, PARITY_ASC);
                  stat_q <= `ST_CHECK;
                  go(S_STAT);
               end else begin
                  cdb_byte_out <= rx_q;
                  cdb_valid_out <= 1'b1;
                  idx_q <= idx_q + 4'h1;
                  if (idx_q == 4'h0) begin
                     len_q <= cdb_len(rx_q);
                     op_q <= rx_q;
                  end
                  if (idx_q != 4'h0 && idx_q == len_q - 4'h1) begin
                     cdb_last_out <= 1'b1;
                     link_q <= rx_q[0];
                     idx_q <= 4'h0;
                     planned_q <= 1'b0;
                     stat_q <= cmd_stat_w;
                     if (op_q != REQ_SENSE_OP && op_q != INQUIRY_OP) begin
                        sval_q[init_q] <= 1'b0;
                     end
                     if (atn_f) begin
                        ret_q <= cmd_nxt_w;
                        go(S_MSGO);
                     end else begin
                        go(cmd_nxt_w);
                     end
                  end else if (atn_f) begin
                     ret_q <= S_CMD;
                     go(S_MSGO);
                  end
               end
            end
            S_EXEC: if (!planned_q) begin
               if (plan_valid_in) begin
                  planned_q <= 1'b1;
                  cnt_q <= plan_len_in;
                  blk_q <= 16'h0000;
                  if (plan_len_in != 16'h0000 && plan_dir_in == `DIR_IN) begin
                     go(S_DIN);
                  end else if (plan_len_in != 16'h0000 && plan_dir_in == `DIR_OUT) begin
                     go(S_DOUT);
                  end
               end
            end else if (end_valid_in) begin
               if (end_check_in) begin
                  set_sense(end_key_in, end_asc_in);
                  stat_q <= `ST_CHECK;
               end else begin
                  stat_q <= link_q ? `ST_INTERM : `ST_GOOD;
               end
               go(S_STAT);
            end
            S_DIN: if (done_w) begin
               data_step(S_DIN);
            end
            S_DOUT: if (done_w) begin
               if (bad_q) begin
                  set_sense(`KEY_ABORTED, PARITY_ASC);
                  stat_q <= `ST_CHECK;
                  go(S_STAT);
               end else begin
                  dout_byte_out <= rx_q;
                  dout_valid_out <= 1'b1;
                  data_step(S_DOUT);
               end
            end
            S_STAT: if (done_w) begin
               mi_q <= (stat_q == `ST_INTERM) ? `MSG_LCC : `MSG_CC;
               go(S_MSGI);
            end
            S_MSGI: if (done_w) begin
               if (mi_q == `MSG_LCC) begin
                  ret_q <= S_CMD;
                  go(atn_f ? S_MSGO : S_CMD);
               end else begin
                  cc_q <= 1'b1;
                  go(atn_f ? S_MSGO : S_FREE);
               end
            end
            default: go(S_FREE);
         endcase
      end
   end
endmodule

// [rtl/scsi_seq_consts.vh]
// Shared constants for the SCSI target phase sequencer.
`ifndef SCSI_SEQ_CONSTS_VH
`define SCSI_SEQ_CONSTS_VH

`define CLK_MHZ 200
`define BUS_SETTLE_NS 400
`define DESKEW_NS 45
`define CABLE_SKEW_NS 10
`define SETTLE_CYC ((`BUS_SETTLE_NS * `CLK_MHZ + 999) / 1000)
`define SKEW_CYC (((`DESKEW_NS + `CABLE_SKEW_NS) * `CLK_MHZ + 999) / 1000)

`define ST_GOOD 8'h00
`define ST_CHECK 8'h02
`define ST_BUSY 8'h08
`define ST_INTERM 8'h10
`define ST_CONFLICT 8'h18
`define ST_TERM 8'h22
`define ST_QFULL 8'h28
`define ST_CODE_MASK 8'h3E

`define MSG_CC 8'h00
`define MSG_EXT 8'h01
`define MSG_ABORT 8'h06
`define MSG_REJECT 8'h07
`define MSG_LCC 8'h0A
`define MSG_BDR 8'h0C
`define MSG_TERM 8'h11
`define MSG_SQT 8'h20
`define MSG_HQT 8'h21
`define MSG_OQT 8'h22

`define KEY_ABORTED 4'hB
`define ASC_ILLMSG 8'h49

`define PH_DOUT 3'h0
`define PH_DIN 3'h1
`define PH_CMD 3'h2
`define PH_STAT 3'h3
`define PH_MSGO 3'h6
`define PH_MSGI 3'h7

`define DIR_IN 2'h1
`define DIR_OUT 2'h2

`endif

// [rtl/seq_fifo.v]
// Synchronous FIFO with valid and ready on both sides.
module seq_fifo #(
   parameter W = 8,
   parameter D = 16,
   parameter AW = 4
) (
   input wire clk_in,
   input wire rst_n_in,
   input wire flush_in,
   input wire in_valid_in,
   input wire [W-1:0] in_data_in,
   output reg in_ready_out,
   output wire out_valid_out,
   output wire [W-1:0] out_data_out,
   input wire out_ready_in
);
   // Pointers wrap freely, so D must be a power of two equal to 2**AW.
   localparam [AW:0] DEPTH = D[AW:0];
   reg [W-1:0] mem [0:D-1];
   reg [AW-1:0] wr_q;
   reg [AW-1:0] rd_q;
   reg [AW:0] cnt_q;
   wire push_w = in_valid_in & in_ready_out;
   wire pop_w = out_valid_out & out_ready_in;
   wire [AW:0] cnt_d = cnt_q + {{AW{1'b0}}, push_w} - {{AW{1'b0}}, pop_w};

   assign out_valid_out = (cnt_q != {(AW+1){1'b0}});
   assign out_data_out = mem[rd_q];

   always @(posedge clk_in) begin
      if (push_w) begin
         mem[wr_q] <= in_data_in;
      end
   end

   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
         in_ready_out <= 1'b0;
      end else if (flush_in) begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
         in_ready_out <= 1'b1;
      end else begin
         if (push_w) begin
            wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop_w) begin
            rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
         end
         cnt_q <= cnt_d;
         in_ready_out <= (cnt_d < DEPTH);
      end
   end
endmodule

// [sim/scsi_seq_sva.sv]
// Port checker for the SCSI target phase sequencer.
module scsi_seq_checker (
   input wire clk_in,
   input wire rst_n_in,
   input wire ack_in,
   input wire req_out,
   input wire cd_out,
   input wire io_out,
   input wire msg_out,
   input wire bsy_out,
   input wire [7:0] db_out,
   input wire dbp_out,
   input wire db_oe_out,
   input wire cdb_valid_out,
   input wire cdb_last_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_ack_rise;
      $rose(ack_in);
   endsequence
   sequence s_stat_byte;
      req_out && db_oe_out && !msg_out && cd_out && io_out;
   endsequence
   property p_req_drop;
      s_ack_rise |-> ##[1:8] !req_out;
   endproperty
   a_req_drop: assert property (p_req_drop) else $error("REQ held after ACK");
   property p_oe_dir;
      db_oe_out |-> io_out;
   endproperty
   a_oe_dir: assert property (p_oe_dir) else $error("data driven in an inbound phase");
   property p_phase_hold;
      req_out |-> $stable({msg_out, cd_out, io_out});
   endproperty
   a_phase_hold: assert property (p_phase_hold) else $error("phase moved under REQ");
   property p_free_quiet;
      !bsy_out |-> !req_out && !db_oe_out;
   endproperty
   a_free_quiet: assert property (p_free_quiet) else $error("bus used while free");
   property p_stat_resv;
      s_stat_byte |-> (db_out & 8'hC1) == 8'h00;
   endproperty
   a_stat_resv: assert property (p_stat_resv) else $error("status reserved bit set");
   property p_stat_code;
      s_stat_byte |-> db_out inside {8'h00, 8'h02, 8'h08, 8'h10, 8'h18, 8'h22, 8'h28};
   endproperty
   a_stat_code: assert property (p_stat_code) else $error("unknown status code");
   property p_par_out;
      req_out && db_oe_out |-> dbp_out == ~^db_out;
   endproperty
   a_par_out: assert property (p_par_out) else $error("outbound parity not odd");
   property p_cdb_last;
      cdb_last_out |-> cdb_valid_out;
   endproperty
   a_cdb_last: assert property (p_cdb_last) else $error("last flag without a byte");
endmodule
bind scsi_target_phase_sequencer scsi_seq_checker chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
   .ack_in(ack_in), .req_out(req_out), .cd_out(cd_out), .io_out(io_out), .msg_out(msg_out),
   .bsy_out(bsy_out), .db_out(db_out), .dbp_out(dbp_out), .db_oe_out(db_oe_out),
   .cdb_valid_out(cdb_valid_out), .cdb_last_out(cdb_last_out));

// [sim/scsi_initiator_model.sv]
// Behavioural initiator that answers each REQ with one ACK.
module scsi_initiator_model (
   input wire clk_in,
   input wire req_in,
   input wire io_in,
   input wire [7:0] tdb_in,
   output logic ack_out,
   output logic [7:0] db_out,
   output logic dbp_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0] txq[$];
   logic [7:0] rx[$];
   int wt = 0;
   int lag = 1;
   initial begin
      ack_out = 1'b0;
      db_out = 8'h00;
      dbp_out = 1'b0;
   end
   task automatic put(input logic [7:0] b, input logic bad);
      txq.push_back({~^b ^ bad, b});
   endtask
   always @(posedge clk_in) begin
      if (req_in && !ack_out) begin
         wt <= wt + 1;
         if (wt == 1 && !io_in && txq.size() > 0) begin
            {dbp_out, db_out} <= txq.pop_front();
         end
         if (wt == lag + 2) begin
            ack_out <= 1'b1;
            wt <= 0;
            if (io_in) begin
               rx.push_back(tdb_in);
            end
         end
      end else if (!req_in && ack_out) begin
         // Released lines show the inverse so a stale byte is never read by chance.
         ack_out <= 1'b0;
         db_out <= ~db_out;
         dbp_out <= ~dbp_out;
      end
   end
endmodule

// [sim/scsi_target_phase_sequencer_bench.sv]
// Self-checking bench for the SCSI target phase sequencer.
module scsi_target_phase_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 0, rst_n_in = 0, sel_start_in = 0, parity_en_in = 0, busy_in = 0;
   logic reserved_in = 0, plan_valid_in = 0, end_valid_in = 0, end_check_in = 0;
   logic din_valid_in = 0, dout_ready_in = 1;
   logic [2:0] reserve_owner_in = 0, sense_sel_in = 3'h2;
   logic [1:0] plan_dir_in = 0;
   logic [3:0] end_key_in = 0;
   logic [7:0] end_asc_in = 0, din_byte_in = 0;
   logic ack_in, dbp_in, req_out, cd_out, io_out, msg_out, bsy_out, dbp_out, db_oe_out;
   logic cdb_valid_out, cdb_last_out, din_ready_out, dout_valid_out, sense_valid_out;
   logic [7:0] db_in, db_out, cdb_byte_out, dout_byte_out;
   logic [11:0] sense_out;
   int error_cnt = 0, check_count = 0, cycles = 0, ncdb = 0;
   int idm = -1, ncl = 0;
   logic [7:0] mb = 8'h00;
   logic atn_in = 0, sel_atn_in = 0, disc_ok_out, cleared_out;
   always #2.5 clk_in = ~clk_in;
   scsi_target_phase_sequencer #(.BLOCK_BYTES(4)) uut (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .ack_in(ack_in), .atn_in(atn_in), .db_in(db_in), .dbp_in(dbp_in), .req_out(req_out),
      .cd_out(cd_out), .io_out(io_out), .msg_out(msg_out), .bsy_out(bsy_out), .db_out(db_out),
      .dbp_out(dbp_out), .db_oe_out(db_oe_out), .sel_start_in(sel_start_in),
      .sel_atn_in(sel_atn_in), .sel_id_ok_in(1'b1), .sel_init_in(3'h2),
      .parity_en_in(parity_en_in), .busy_in(busy_in), .reserved_in(reserved_in),
      .reserve_owner_in(reserve_owner_in),
      .queue_full_in(1'b0), .cdb_byte_out(cdb_byte_out), .cdb_valid_out(cdb_valid_out),
      .cdb_last_out(cdb_last_out), .plan_valid_in(plan_valid_in), .plan_dir_in(plan_dir_in),
      .plan_len_in(16'h0010), .end_valid_in(end_valid_in), .end_check_in(end_check_in),
      .end_key_in(end_key_in), .end_asc_in(end_asc_in), .din_valid_in(din_valid_in),
      .din_byte_in(din_byte_in), .din_ready_out(din_ready_out), .dout_byte_out(dout_byte_out),
      .dout_valid_out(dout_valid_out), .dout_ready_in(dout_ready_in), .disc_ok_out(disc_ok_out),
      .cleared_out(cleared_out), .sense_sel_in(sense_sel_in), .sense_valid_out(sense_valid_out),
      .sense_out(sense_out));
   scsi_initiator_model ini (.clk_in(clk_in), .req_in(req_out), .io_in(io_out),
      .tdb_in(db_out), .ack_out(ack_in), .db_out(db_in), .dbp_out(dbp_in));
   always @(posedge clk_in) begin
      if (cdb_valid_out === 1'b1) ncdb <= ncdb + 1;
      if (cleared_out === 1'b1) ncl <= ncl + 1;
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         error_cnt++;
         conclude();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Runs one connection; dl is the count of data bytes expected before status.
   task automatic cmd(input logic [7:0] op, input int n, input int bad, input logic run,
         input logic [1:0] dir, input int dl);
      int k;
      ncdb = 0;
      ini.rx.delete();
      ini.txq.delete();
      if (idm >= 0) ini.put(idm[7:0], 1'b0);
      for (k = 0; k < n; k++) ini.put(k == 0 ? op : k == 1 ? mb : 8'h00, k == bad);
      @(posedge clk_in);
      sel_start_in <= 1'b1;
      sel_atn_in <= (idm >= 0);
      @(posedge clk_in);
      sel_start_in <= 1'b0;
      sel_atn_in <= 1'b0;
      @(negedge clk_in);
      if (run) begin
         for (k = 0; k < 4000 && cdb_last_out !== 1'b1; k++) @(negedge clk_in);
         @(posedge clk_in);
         plan_valid_in <= 1'b1;
         plan_dir_in <= dir;
         @(posedge clk_in);
         plan_valid_in <= 1'b0;
         for (k = 0; k < 9000 && ini.rx.size() < dl; k++) @(negedge clk_in);
         // The last data handshake must close before the end strobe counts.
         repeat (20) @(posedge clk_in);
         end_valid_in <= 1'b1;
         @(posedge clk_in);
         end_valid_in <= 1'b0;
      end
      for (k = 0; k < 6000 && !(bsy_out === 1'b0 && ini.rx.size() > dl); k++) @(negedge clk_in);
      repeat (4) @(negedge clk_in);
   endtask
   task automatic t_good;
      cmd(8'h00, 6, -1, 1'b1, 2'h0, 0);
      chk(ncdb, 6);
      chk(ini.rx[0], 8'h00);
      chk(ini.rx[1], 8'h00);
      chk(bsy_out, 1'b0);
   endtask
   task automatic t_check;
      end_check_in <= 1'b1;
      end_key_in <= 4'h3;
      end_asc_in <= 8'h11;
      cmd(8'h28, 10, -1, 1'b1, 2'h0, 0);
      end_check_in <= 1'b0;
      chk(ncdb, 10);
      chk(ini.rx[0], 8'h02);
      chk(sense_out, 12'h311);
      cmd(8'hA8, 12, -1, 1'b1, 2'h0, 0);
      chk(ncdb, 12);
      chk(sense_valid_out, 1'b0);
   endtask
   task automatic t_busy;
      busy_in <= 1'b1;
      cmd(8'h00, 6, -1, 1'b0, 2'h0, 0);
      busy_in <= 1'b0;
      chk(ini.rx[0], 8'h08);
   endtask
   task automatic t_conflict;
      // A slow initiator here stretches every handshake.
      ini.lag = 9;
      reserved_in <= 1'b1;
      reserve_owner_in <= 3'h5;
      cmd(8'h00, 6, -1, 1'b0, 2'h0, 0);
      reserved_in <= 1'b0;
      ini.lag = 1;
      chk(ini.rx[0], 8'h18);
   endtask
   task automatic t_parity;
      parity_en_in <= 1'b1;
      cmd(8'h00, 6, 2, 1'b0, 2'h0, 0);
      parity_en_in <= 1'b0;
      chk(ini.rx[0], 8'h02);
      chk(ini.rx[1], 8'h00);
      chk(sense_out, 12'hB00);
   endtask
   task automatic t_din;
      int k;
      for (k = 0; k < 16; k++) begin
         @(posedge clk_in);
         din_valid_in <= 1'b1;
         din_byte_in <= 8'h40 + k[7:0];
      end
      @(posedge clk_in);
      din_valid_in <= 1'b0;
      @(negedge clk_in);
      chk(din_ready_out, 1'b0);
      cmd(8'h08, 6, -1, 1'b1, 2'h1, 16);
      for (k = 0; k < 16; k++) chk(ini.rx[k], 8'h40 + k[7:0]);
      chk(ini.rx[16], 8'h00);
      chk(din_ready_out, 1'b1);
   endtask
   task automatic t_msg;
      idm = 8'hC0;
      cmd(8'h00, 6, -1, 1'b1, 2'h0, 0);
      chk(disc_ok_out, 1'b1);
      chk(ncdb, 6);
      idm = 8'h00;
      cmd(8'h00, 6, -1, 1'b0, 2'h0, -1);
      idm = -1;
      chk(ini.rx.size(), 0);
      chk(sense_out, 12'hB49);
      atn_in <= 1'b1;
      mb = 8'h06;
      cmd(8'h00, 2, -1, 1'b0, 2'h0, -1);
      atn_in <= 1'b0;
      mb = 8'h00;
      chk(ncdb, 1);
      chk(ncl, 1);
      chk(ini.rx.size(), 0);
      chk(disc_ok_out, 1'b0);
   endtask
   initial begin
      repeat (16) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      t_good();
      t_check();
      t_busy();
      t_conflict();
      t_parity();
      t_din();
      t_msg();
      conclude();
   end
endmodule
